/* src/ned_unit.sv */
// What this block does
// - Word negate: invert source, add one.
// - Word negate: equals on zero, fault cleared.
// - Word negate: negative copies result bit 15.
// - Most negative word negates to itself.
// - Double negate: zero minus high:low pair.
// - Double ops: flags from full 32 bits.
// - Extend: copy low, fill high by sign.
// - Top control digit picks decoder mode.
// - Digit mode: one bit per word.
// - Digits taken upward, wrapping to zero.
// - Byte mode: one bit per sixteen words.
// - Starting at byte one wraps to zero.
// - Bad control word raises the fault flag.
`timescale 1ns/1ps
module ned_unit
   import ned_pkg::*;
#(
   parameter int RES_DEPTH = RES_WORDS
) (
   // Clock, reset and clock enable.
   input logic clk_i,
   input logic rstn_i,
   input logic ce_i,
   // Classic register bus.
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Status outputs.
   output logic busy_o,
   output logic irq_o
);
   // The result window is addressed by five bits and cannot be resized.
   // A wrong depth stops elaboration rather than leaving words unreachable.
   if (RES_DEPTH != RES_WORDS) begin : g_depth_check
      $error("ned_unit: RES_DEPTH must equal 32");
   end

   // Merges new bytes into an old word under the byte enables.
   // Lanes without an enable keep their old contents.
   function automatic logic [31:0] ned_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      ned_merge = res;
   endfunction

   // Bus handshake registers.
   logic ack_ff; // Acknowledge, high for one cycle.
   logic [31:0] dat_ff; // Read data captured with the acknowledge.
   // Software registers.
   logic [31:0] src_ff; // High word is S+1, low word is S.
   logic [15:0] ctrl_ff; // Decoder control word.
   logic [1:0] op_ff; // Operation in progress or last run.
   logic [FLG_W-1:0] flg_ff; // Fault, equals and negative flags.
   logic [IRQ_W-1:0] ist_ff; // Sticky interrupt status.
   logic [IRQ_W-1:0] imsk_ff; // Interrupt mask.
   // Sequencer.
   ned_state_t state_ff; // Current state.
   logic [4:0] idx_ff; // Result word being written.
   logic [15:0] res_ff [RES_WORDS]; // Result word storage.

   // Bus decode.
   // A request is taken only while no acknowledge is out, so a master
   // that holds its strobe through the ack edge is not served twice.
   wire req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire wr = req && wb_we_i;
   // The top address bit splits the registers from the result window.
   wire rd_win = wb_adr_i[RES_WIN_BIT];
   wire [7:0] reg_adr = {wb_adr_i[7:2], 2'b00};
   wire hit_cmd = !rd_win && (reg_adr == OFS_CMD);
   wire hit_src = !rd_win && (reg_adr == OFS_SRC);
   wire hit_ctrl = !rd_win && (reg_adr == OFS_CTRL);
   wire hit_flag = !rd_win && (reg_adr == OFS_FLAG);
   wire hit_ist = !rd_win && (reg_adr == OFS_IST);
   wire hit_imsk = !rd_win && (reg_adr == OFS_IMSK);
   // Busy is decoded straight from the state register.
   wire busy = (state_ff == ST_RUN);
   // Operands are locked while an operation runs.
   wire wr_src = wr && hit_src && !busy;
   wire wr_ctrl = wr && hit_ctrl && !busy;
   // A command write starts an operation only from idle.
   wire start = wr && hit_cmd && wb_sel_i[0] && !busy;
   wire [1:0] start_op = wb_dat_i[1:0];
   wire [31:0] src_merged = ned_merge(src_ff, wb_dat_i, wb_sel_i);
   wire [31:0] ctrl_merged = ned_merge({16'h0000, ctrl_ff}, wb_dat_i,
                                       wb_sel_i);

   // Arithmetic on the latched operands.
   // All results are formed every cycle; the sequencer decides when one
   // is stored.
   wire [15:0] s_lo = src_ff[15:0];
   wire [15:0] s_hi = src_ff[31:16];
   // Inverting and adding one; 8000 comes back as 8000.
   wire [15:0] neg_word = ~s_lo + 16'h0001;
   // High word S+1 is the more significant half.
   wire [31:0] neg_dbl = 32'h0000_0000 - {s_hi, s_lo};
   // Upper half filled with copies of source bit 15.
   wire [31:0] sext = {{16{s_lo[15]}}, s_lo};
   wire dbl_op = (op_ff == OP_TWOS_COMPLEMENT_DOUBLE);
   wire [31:0] r32 = dbl_op ? neg_dbl : sext;
   wire is_dec = (op_ff == OP_ONE_HOT_DECODER);
   wire is_word = (op_ff == OP_TWOS_COMPLEMENT_WORD);

   // Decoder query for the word being written.
   // The decoder is purely combinational and answers within the cycle.
   ned_dec_if dec_if ();
   assign dec_if.ctrl = ctrl_ff;
   assign dec_if.src = s_lo;
   assign dec_if.idx = idx_ff;

   ned_one_hot_decoder u_dec (
      .dec_if(dec_if)
   );

   // Words per operation: one, two, or what the decoder asks for.
   // The index counts up from zero, and the last word is the one whose
   // successor equals the word count.
   wire [5:0] nwords = is_dec ? dec_if.nwords :
                       (is_word ? 6'h01 : 6'h02);
   wire [5:0] idx_next = {1'b0, idx_ff} + 6'h01;
   wire last = (idx_next == nwords);
   // A refused decode writes nothing and ends at once.
   wire dec_bad = is_dec && dec_if.bad;
   wire finish = busy && (last || dec_bad);
   wire mem_we = busy && !dec_bad;
   // Data for the word being written.
   wire [15:0] wr_word = is_dec ? dec_if.word :
                         (is_word ? neg_word :
                          (idx_ff[0] ? r32[31:16] : r32[15:0]));

   // Flags computed at the end of an operation.
   // They are posted only when an operation ends, so software never sees
   // a half-finished set.
   wire eq16 = (neg_word == 16'h0000);
   wire eq32 = (r32 == 32'h0000_0000);
   logic [FLG_W-1:0] nxt_flg; // Flags after the current finish.
   always_comb begin
      // Start from the held flags so an untouched flag keeps its value.
      nxt_flg = flg_ff;
      if (is_dec) begin
         // Only the fault flag changes for decoding.
         nxt_flg[FLG_FAULT] = dec_if.bad;
      end else if (is_word) begin
         // Equals on a zero word, fault always cleared.
         nxt_flg[FLG_FAULT] = 1'b0;
         nxt_flg[FLG_EQUAL] = eq16;
         // Negative follows bit 15 of the result.
         nxt_flg[FLG_NEGATIVE] = neg_word[15];
      end else begin
         // Flags from the whole pair, sign from the upper word.
         nxt_flg[FLG_FAULT] = 1'b0;
         nxt_flg[FLG_EQUAL] = eq32;
         nxt_flg[FLG_NEGATIVE] = r32[31];
      end
   end

   // Interrupt events; a new event beats a clear in the same cycle.
   // Only a refused decode raises the fault event, since the arithmetic
   // operations always clear the fault flag.
   wire [IRQ_W-1:0] ev = {finish && nxt_flg[FLG_FAULT], finish};
   wire [IRQ_W-1:0] ist_clr = (wr && hit_ist && wb_sel_i[0]) ?
                              wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}};
   wire [IRQ_W-1:0] nxt_ist = (ist_ff & ~ist_clr) | ev;

   // Read data selection.
   // Result words are sixteen bits wide; the upper half reads as zero.
   logic [31:0] rd_data; // Value returned for the current address.
   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_win) begin
         rd_data = {16'h0000, res_ff[wb_adr_i[6:2]]};
      end else if (hit_cmd) begin
         rd_data[1:0] = op_ff;
         rd_data[CMD_BUSY_BIT] = busy;
      end else if (hit_src) begin
         rd_data = src_ff;
      end else if (hit_ctrl) begin
         rd_data = {16'h0000, ctrl_ff};
      end else if (hit_flag) begin
         rd_data[FLG_W-1:0] = flg_ff;
      end else if (hit_ist) begin
         rd_data[IRQ_W-1:0] = ist_ff;
      end else if (hit_imsk) begin
         rd_data[IRQ_W-1:0] = imsk_ff;
      end else begin
         // Unmapped addresses read as zero and still acknowledge.
         rd_data = 32'h0000_0000;
      end
   end

   // Bus acknowledge one cycle after the request, dropped the next.
   // Read data is captured when taken and held until the next read.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_ff <= req;
         if (req && !wb_we_i) begin
            dat_ff <= rd_data;
         end
      end
   end

   // Operand registers, written by software while idle.
   // Writes while busy are acknowledged but dropped, so a running
   // operation always sees the operands it started with.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         src_ff <= SRC_RST;
         ctrl_ff <= CTRL_RST;
      end else if (ce_i) begin
         if (wr_src) begin
            src_ff <= src_merged;
         end
         if (wr_ctrl) begin
            ctrl_ff <= ctrl_merged[15:0];
         end
      end
   end

   // Sequencer: one result word per cycle, flags posted at the end.
   // The index is cleared on every start, so a new operation never
   // inherits the position of an earlier one.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= ST_IDLE;
         idx_ff <= 5'h00;
         op_ff <= OP_TWOS_COMPLEMENT_WORD;
         flg_ff <= {FLG_W{1'b0}};
      end else if (ce_i) begin
         case (state_ff)
            ST_IDLE: begin
               // A command latches its operation and resets the index.
               if (start) begin
                  op_ff <= start_op;
                  idx_ff <= 5'h00;
                  state_ff <= ST_RUN;
               end
            end
            ST_RUN: begin
               // Advance, or post flags and return to idle.
               if (finish) begin
                  flg_ff <= nxt_flg;
                  state_ff <= ST_IDLE;
               end else begin
                  idx_ff <= idx_next[4:0];
               end
            end
            default: begin
               // An illegal code falls back to idle.
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Result storage; words not written keep their old contents.
   // A refused decode writes nothing, so earlier results stay readable.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < RES_WORDS; i++) begin
            res_ff[i] <= 16'h0000;
         end
      end else if (ce_i && mem_we) begin
         res_ff[idx_ff] <= wr_word;
      end
   end

   // Interrupt status and mask.
   // The mask gates only the output line, never the status bits.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ist_ff <= {IRQ_W{1'b0}};
         imsk_ff <= IMSK_RST;
      end else if (ce_i) begin
         ist_ff <= nxt_ist;
         if (wr && hit_imsk && wb_sel_i[0]) begin
            imsk_ff <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   // Outputs.
   // The interrupt line follows registered status and mask bits only.
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign busy_o = busy;
   assign irq_o = |(ist_ff & imsk_ff);
endmodule // ned_unit

/* common/ned_pkg.sv */
package ned_pkg;
   // Width of one operand or result word.
   localparam int DATA_W = 16;
   // Number of result words the decoder can fill.
   localparam int RES_WORDS = 32;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_SRC = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0C;
   localparam logic [7:0] OFS_IST = 8'h10;
   localparam logic [7:0] OFS_IMSK = 8'h14;
   // Address bit that selects the result word window.
   localparam int RES_WIN_BIT = 7;
   // Operation codes written to the command register.
   localparam logic [1:0] OP_TWOS_COMPLEMENT_WORD = 2'h0;
   localparam logic [1:0] OP_TWOS_COMPLEMENT_DOUBLE = 2'h1;
   localparam logic [1:0] OP_SIGN_EXTEND = 2'h2;
   localparam logic [1:0] OP_ONE_HOT_DECODER = 2'h3;
   // Busy bit position in the command register.
   localparam int CMD_BUSY_BIT = 8;
   // Condition flag positions.
   localparam int FLG_FAULT = 0;
   localparam int FLG_EQUAL = 1;
   localparam int FLG_NEGATIVE = 2;
   localparam int FLG_W = 3;
   // Interrupt status and mask positions.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_W = 2;
   // Control word digit positions.
   localparam int CW_MODE_LSB = 12;
   localparam int CW_RSV_LSB = 8;
   localparam int CW_CNT_LSB = 4;
   localparam int CW_START_LSB = 0;
   // Mode digit values.
   localparam logic [3:0] MODE_DIGIT = 4'h0;
   localparam logic [3:0] MODE_BYTE = 4'h1;
   // Largest count-minus-one and start index per mode.
   localparam logic [3:0] DIGIT_MAX = 4'h3;
   localparam logic [3:0] BYTE_MAX = 4'h1;
   // Reset values of the software registers.
   localparam logic [31:0] SRC_RST = 32'h0000_0000;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IMSK_RST = 2'h0;
   // Sequencer states, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } ned_state_t;
endpackage

/* common/ned_dec_if.sv */
`timescale 1ns/1ps
// Carries one decode query from the sequencer to the decoder.
interface ned_dec_if;
   logic [15:0] ctrl; // Control word.
   logic [15:0] src; // Source word.
   logic [4:0] idx; // Result word being produced.
   logic [15:0] word; // Decoded result word.
   logic [5:0] nwords; // Number of result words.
   logic bad; // Control word out of range.
   modport user(output ctrl, src, idx, input word, nwords, bad);
   modport dec(input ctrl, src, idx, output word, nwords, bad);
endinterface

/* src/ned_one_hot_decoder.sv */
`timescale 1ns/1ps
module ned_one_hot_decoder
   import ned_pkg::*;
(
   ned_dec_if.dec dec_if
);
   // Returns a word with only the bit at the given position set.
   function automatic logic [15:0] ned_onehot(input logic [3:0] pos);
      ned_onehot = 16'h0001 << pos;
   endfunction

   // Control word digits.
   wire [3:0] mode = dec_if.ctrl[CW_MODE_LSB +: 4];
   wire [3:0] rsv = dec_if.ctrl[CW_RSV_LSB +: 4];
   wire [3:0] cnt = dec_if.ctrl[CW_CNT_LSB +: 4];
   wire [3:0] start = dec_if.ctrl[CW_START_LSB +: 4];
   // Mode selection by the top digit.
   wire byte_mode = (mode == MODE_BYTE);
   // Range checks per mode.
   wire digit_ok = (mode == MODE_DIGIT) && (cnt <= DIGIT_MAX) &&
                   (start <= DIGIT_MAX);
   wire byte_ok = byte_mode && (cnt <= BYTE_MAX) && (start <= BYTE_MAX);
   // A control word outside the ranges is refused.
   assign dec_if.bad = !((rsv == 4'h0) && (digit_ok || byte_ok));
   // Units to decode, and the result words they occupy.
   wire [5:0] units = {2'b00, cnt} + 6'h01;
   assign dec_if.nwords = byte_mode ? {units[1:0], 4'h0} : units;
   // Digits are read upward from the start and wrap.
   wire [1:0] dsel = start[1:0] + dec_if.idx[1:0];
   wire [3:0] nibble = dec_if.src[{dsel, 2'b00} +: 4];
   // The second byte is the other one, so byte 1 wraps to 0.
   wire bsel = start[0] ^ dec_if.idx[4];
   wire [7:0] byte_v = dec_if.src[{bsel, 3'b000} +: 8];
   // Byte mode sets one bit in a block of sixteen words.
   wire [15:0] byte_word = (byte_v[7:4] == dec_if.idx[3:0]) ?
                           ned_onehot(byte_v[3:0]) : 16'h0000;
   // Digit mode sets one bit of one word.
   assign dec_if.word = byte_mode ? byte_word : ned_onehot(nibble);
endmodule // ned_one_hot_decoder

/* test/ned_unit_props.sv */
`timescale 1ns/1ps
// Watches the bus handshake, busy length and interrupt line of the unit.
module ned_unit_props
   import ned_pkg::*;
#(
   parameter int RES_DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic busy_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // A request is taken on an edge with the strobe up and no ack out.
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   // A command write that the idle unit accepts.
   wire cmd_go = take && wb_we_i && wb_adr_i[7:2] == OFS_CMD[7:2]
      && wb_sel_i[0] && !busy_o;
   // Start of each kind of operation.
   sequence s_word;
      cmd_go && wb_dat_i[1:0] == OP_TWOS_COMPLEMENT_WORD;
   endsequence
   sequence s_pair;
      cmd_go && (wb_dat_i[1:0] == OP_TWOS_COMPLEMENT_DOUBLE
         || wb_dat_i[1:0] == OP_SIGN_EXTEND);
   endsequence
   sequence s_dec;
      cmd_go && wb_dat_i[1:0] == OP_ONE_HOT_DECODER;
   endsequence
   a_ack_next: assert property (take |=> wb_ack_o)
      else $error("No ack one cycle after a taken request.");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack stood longer than one cycle.");
   a_ack_cause: assert property (!take |=> !wb_ack_o)
      else $error("Ack without a taken request.");
   a_word_len: assert property (s_word |=> busy_o ##1 !busy_o)
      else $error("Word negate did not run one cycle.");
   a_pair_len: assert property (
      s_pair |=> busy_o[*2] ##1 !busy_o)
      else $error("Pair operation did not run two cycles.");
   a_dec_bound: assert property (
      s_dec |=> busy_o ##[1:32] !busy_o)
      else $error("Decode ran past thirty-two words.");
   a_busy_cause: assert property ($rose(busy_o) |-> $past(cmd_go))
      else $error("Busy rose without an accepted command.");
   a_read_hold: assert property (
      !$past(take && !wb_we_i) |-> $stable(wb_dat_o))
      else $error("Read data moved without a read.");
   a_irq_rise: assert property (
      $rose(irq_o) |-> $fell(busy_o) || $rose(wb_ack_o))
      else $error("Interrupt rose without an end or a write.");
   a_irq_fall: assert property ($fell(irq_o) |-> $rose(wb_ack_o))
      else $error("Interrupt fell without a write.");
endmodule // ned_unit_props
bind ned_unit ned_unit_props #(.RES_DEPTH(RES_DEPTH)) u_ned_unit_props (
   .clk_i, .rstn_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o, .irq_o);

/* test/ned_seq_model.sv */
`timescale 1ns/1ps
// Sequencer side: issues classic single bus cycles to the unit.
module ned_seq_model (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   logic hung = 1'b0; // Set when an answer never came.
   initial {cyc_o, we_o, adr_o, sel_o, dat_o} = '0;
   // One cycle, held until ack is seen high at a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      we_o <= w;
      adr_o <= a; // All result words sit in one window.
      sel_o <= 4'hF;
      dat_o <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 20);
      hung = (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      we_o <= 1'b0;
   endtask
endmodule // ned_seq_model

/* test/ned_unit_tb.sv */
`timescale 1ns/1ps
// Drives the unit through register accesses and checks every result.
module ned_unit_tb;
   import ned_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cyc, we, ack, busy, irq;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q, e, f;
   int n_fail = 0;
   int num_checks = 0;
   logic [15:0] nv[5] = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000, 16'hFFFF};
   logic [31:0] dv[4] = '{32'h0, 32'h1, 32'h8000_7FFF, 32'hAAAA_8000};
   logic [15:0] bc[6] = '{16'h0040, 16'h0004, 16'h2000, 16'h0100,
      16'h1020, 16'h1002};
   initial forever #50 clk_i = ~clk_i;
   ned_unit u_ned_unit (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .busy_o(busy), .irq_o(irq));
   ned_seq_model u_ned_seq_model (.clk_i(clk_i), .ack_i(ack),
      .dat_i(rdat), .cyc_o(cyc), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat));
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Compares one word against its expected value.
   task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] s);
      num_checks++;
      if (s !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   // One bus cycle; a lost answer ends the run.
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      u_ned_seq_model.xfer(w, a, d, q);
      if (u_ned_seq_model.hung) begin
         chk("bus ack", 32'h1, 32'h0);
         results();
      end
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [31:0] x);
      bus(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask
   // Loads operands and starts one operation.
   task automatic start(input logic [1:0] op, input logic [31:0] s,
      input logic [15:0] c);
      bus(1'b1, OFS_SRC, s);
      bus(1'b1, OFS_CTRL, {16'h0000, c});
      bus(1'b1, OFS_CMD, {30'h0, op});
   endtask
   // Waits, bounded, for busy to drop.
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      if (busy !== 1'b0) begin
         chk("busy end", 32'h0, 32'h1);
         results();
      end
   endtask
   // Runs a decode and checks every word it must write.
   task automatic dec(input logic [15:0] s, input logic [15:0] c);
      int nw;
      logic [7:0] b;
      start(OP_ONE_HOT_DECODER, {16'h0, s}, c);
      idle();
      nw = (c[12] ? 16 : 1) * (int'(c[7:4]) + 1);
      for (int k = 0; k < nw; k++) begin
         b = s[8 * ((c[0] + k / 16) % 2) +: 8];
         if (c[12])
            e = (b[7:4] == k % 16) ? 32'h1 << b[3:0] : 32'h0;
         else
            e = 32'h1 << s[4 * ((c[3:0] + k) % 4) +: 4];
         if (c[12])
            rdchk("dec byte", 8'h80 + 8'(4 * k), e);
         else
            rdchk("dec digit", 8'h80 + 8'(4 * k), e);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int a = 0; a < 6; a++)
         rdchk("reset reg", 8'(4 * a), 32'h0);
      $display("Test reset done");
      foreach (nv[i]) begin
         e = {16'h0, ~nv[i] + 16'h1};
         start(OP_TWOS_COMPLEMENT_WORD, {16'h5A5A, nv[i]}, 16'h0);
         idle();
         rdchk("neg word", 8'h80, e);
         f = {29'h0, e[15], e == 0, 1'b0};
         rdchk("neg flags", OFS_FLAG, f);
      end
      $display("Test word negate done");
      for (int op = 1; op < 3; op++)
         foreach (dv[i]) begin
            e = (op == 1) ? 32'h0 - dv[i] : {{16{dv[i][15]}}, dv[i][15:0]};
            start(2'(op), dv[i], 16'h0);
            idle();
            rdchk("pair low", 8'h80, {16'h0, e[15:0]});
            rdchk("pair high", 8'h84, e >> 16);
            f = {29'h0, e[31], e == 0, 1'b0};
            rdchk("pair flags", OFS_FLAG, f);
         end
      $display("Test pair done");
      dec(16'h1A2B, 16'h0031);
      dec(16'h1A2B, 16'h0003);
      rdchk("dec flags", OFS_FLAG, 32'h4);
      dec(16'h12F3, 16'h1011);
      dec(16'h12F3, 16'h1000);
      foreach (bc[i]) begin
         start(OP_ONE_HOT_DECODER, 32'h0, bc[i]);
         idle();
         rdchk("bad flags", OFS_FLAG, 32'h5);
      end
      $display("Test decode done");
      chk("irq masked", 32'h0, {31'h0, irq});
      rdchk("irq status", OFS_IST, 32'h3);
      bus(1'b1, OFS_IMSK, 32'h2);
      chk("irq on", 32'h1, {31'h0, irq});
      bus(1'b1, OFS_IST, 32'h2);
      chk("irq clear", 32'h0, {31'h0, irq});
      rdchk("irq left", OFS_IST, 32'h1);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h40, 32'h0);
      bus(1'b1, OFS_FLAG, 32'h7);
      rdchk("flag ro", OFS_FLAG, 32'h5);
      $display("Test registers done");
      start(OP_ONE_HOT_DECODER, 32'h0000_1234, 16'h1011);
      chk("busy pin", 32'h1, {31'h0, busy});
      bus(1'b1, OFS_SRC, 32'hDEAD_BEEF);
      rdchk("cmd busy", OFS_CMD, 32'h0000_0103);
      idle();
      rdchk("src kept", OFS_SRC, 32'h0000_1234);
      rdchk("dec clear", OFS_FLAG, 32'h4);
      $display("Test busy refusal done");
      results();
   end
endmodule // ned_unit_tb
